// >>> ssp_pkg.sv
// shared constants and types of the serial frame-select block
package ssp_pkg;

  localparam int CHAR_W      = 8;
  localparam int CNT_W       = $clog2(CHAR_W);
  localparam int FIFO_DEPTH  = 16;
  localparam int SYNC_W      = 4;

  localparam logic [CNT_W-1:0]  LAST_BIT     = CNT_W'(CHAR_W - 1);
  localparam logic [CNT_W-1:0]  PRE_LAST_BIT = CNT_W'(CHAR_W - 2);
  localparam logic [CHAR_W-1:0] ALL_ONES     = {CHAR_W{1'b1}};

  // frame select mode codes
  localparam logic [1:0] MODE_SPI     = 2'h0;
  localparam logic [1:0] MODE_PULSE   = 2'h2;
  localparam logic [1:0] MODE_FRAMING = 2'h3;

  // baud divisor of zero means the longest half period
  localparam logic [15:0] BAUD_MAX = 16'hffff;
  localparam logic [15:0] BAUD_ONE = 16'h0001;

  // one sck period of lead before the first bit, counted in half periods
  localparam logic LEAD_LAST_HALF = 1'h1;

  typedef struct packed {
    logic        enable;
    logic        master_enable_bit;
    logic        select_direction_bit;
    logic        select_polarity_bit;
    logic        clock_polarity_bit;
    logic [1:0]  frame_select_mode_field;
    logic [15:0] baud_div;
  } cfg_type;

  typedef struct packed {
    logic              has_cmd;
    logic              select_value_bit;
    logic              end_of_frame_bit;
    logic [CHAR_W-1:0] data;
  } tx_word_type;

  typedef struct packed {
    logic tx_underrun_flag;
    logic rx_overrun_flag;
    logic collision_flag;
  } err_type;

  typedef struct packed {
    logic    transfer_status_bit;
    logic    tx_buffer_empty_flag;
    logic    rx_buffer_full_flag;
    err_type err;
  } status_type;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT} state_type;

endpackage : ssp_pkg

// >>> ssp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  // resets high: idle pull-up level, avoids a false select after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '1;
      q_r    <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule : ssp_sync

// >>> ssp_tx_fifo.sv
// transmit word buffer with valid/ready on both sides
`timescale 1ns/1ps
module ssp_tx_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] wr_ptr_nxt;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          ready_r;
  logic          ready_nxt;
  logic          valid_r;
  logic          valid_nxt;
  logic          push;
  logic          pop;

  always_comb begin
    push       = in_valid_i & ready_r;
    pop        = out_ready_i & valid_r;
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    cnt_nxt    = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ready_nxt  = cnt_nxt != (AW+1)'(DEPTH);
    valid_nxt  = cnt_nxt != '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      ready_r  <= 1'b1;
      valid_r  <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r    <= cnt_nxt;
      ready_r  <= ready_nxt;
      valid_r  <= valid_nxt;
    end
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  assign in_ready_o  = ready_r;
  assign out_valid_o = valid_r;
  assign out_data_o  = mem_r[rd_ptr_r];

endmodule : ssp_tx_fifo

// >>> ssp_frame_select.sv
// frame-select engine of the synchronous serial port
// Functional notes
// - mode 00: select pin follows the select value bit directly.
// - select value comes from a command write or together with a data word.
// - SPI mode: select stays asserted across characters while the value bit is set.
// - end-of-frame set: clear value and end-of-frame bits after the last bit.
// - software clearing the value bit also ends an SPI frame.
// - completion shown by receive-full and by the transfer status bit.
// - SPI master never flags underrun or overrun; it pauses until data read and written.
// - slave missing service flags underrun or overrun and sends all ones.
// - SPI mode: sck toggles only during a character, one period per bit.
// - mode 10: value bit is only a start request, not the pin.
// - pulse mode: one-period pulse before first bit, then clock runs continuously.
// - pulse mode, buffer empty at character end: stop, underrun, clear value bit.
// - mode 11: select level follows the value bit, marking channels.
// - framing mode: select change leads its first data bit by one period.
// - framing mode, no data left: stop, restore select and value, underrun.
// - master enable set makes a master; select pin normally an output.
// - master with select as input flags collision when select is asserted.
// - master enable and select direction both clear make a slave.
// - slave with no data written before first edge sends all ones.
// - characters shift most significant bit first on both data lines.
// - at character end the next word loads and received data becomes readable.
// - error flags clear only by writing a one.
// - a slave ignores sck unless its select is asserted.
`timescale 1ns/1ps
module ssp_frame_select #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // configuration
  input  wire ssp_pkg::cfg_type             cfg_i,
  // command byte write
  input  wire logic                         cmd_wr_i,
  input  wire logic                         cmd_select_i,
  input  wire logic                         cmd_eof_i,
  // transmit data words
  input  wire logic                         tx_valid_i,
  input  wire ssp_pkg::tx_word_type         tx_word_i,
  output logic                              tx_ready_o,
  // receive data
  output logic                              rx_valid_o,
  output logic [ssp_pkg::CHAR_W-1:0]        rx_data_o,
  input  wire logic                         rx_read_i,
  // status and command readback
  output ssp_pkg::status_type               status_o,
  input  wire ssp_pkg::err_type             err_clr_i,
  output logic                              select_value_o,
  output logic                              end_of_frame_o,
  // pins
  input  wire logic                         sck_i,
  output logic                              sck_o,
  output logic                              sck_oe_n_o,
  input  wire logic                         sel_i,
  output logic                              sel_o,
  output logic                              sel_oe_n_o,
  input  wire logic                         mosi_i,
  output logic                              mosi_o,
  output logic                              mosi_oe_n_o,
  input  wire logic                         miso_i,
  output logic                              miso_o,
  output logic                              miso_oe_n_o
);
  import ssp_pkg::*;

  state_type         state_r, state_nxt;
  logic [CNT_W-1:0]  bit_cnt_r, bit_cnt_nxt;
  logic [15:0]       baud_cnt_r, baud_cnt_nxt;
  logic              lead_cnt_r, lead_cnt_nxt;
  logic              sck_r, sck_nxt;
  logic              sck_prev_r, sck_prev_nxt;
  logic [CHAR_W-1:0] tx_shift_r, tx_shift_nxt;
  logic [CHAR_W-1:0] rx_shift_r, rx_shift_nxt;
  logic [CHAR_W-1:0] rx_data_r, rx_data_nxt;
  logic              rx_full_r, rx_full_nxt;
  logic              sel_value_r, sel_value_nxt;
  logic              eof_r, eof_nxt;
  logic              frame_lvl_r, frame_lvl_nxt;
  logic              ones_r, ones_nxt;
  logic              sel_pin_r, sel_pin_nxt;
  logic [3:0]        oe_n_r, oe_n_nxt;
  err_type           err_r, err_nxt, set_err;
  status_type        status_r, status_nxt;

  logic [SYNC_W-1:0] pins_s;
  logic              sck_s, sel_s, miso_s, mosi_s;
  logic              fifo_valid, pop, load_ones, done;
  logic              is_master, is_slave, sel_active, half_tick;
  logic              lead, trail, start_ok, sel_assert, smp;
  logic [15:0]       baud_reload;
  logic [1:0]        mode;
  logic [$bits(tx_word_type)-1:0] fifo_out;
  tx_word_type       head;

  // slave pins cross into the system clock here
  ssp_sync #(.W(SYNC_W)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({sck_i, sel_i, miso_i, mosi_i}),
    .q_o   (pins_s)
  );
  assign {sck_s, sel_s, miso_s, mosi_s} = pins_s;

  ssp_tx_fifo #(.W($bits(tx_word_type)), .DEPTH(DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (tx_valid_i),
    .in_data_i   (tx_word_i),
    .in_ready_o  (tx_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_out),
    .out_ready_i (pop)
  );
  assign head = fifo_out;

  always_comb begin
    mode        = cfg_i.frame_select_mode_field;
    is_master   = cfg_i.enable & cfg_i.master_enable_bit;
    is_slave    = cfg_i.enable & ~cfg_i.master_enable_bit & ~cfg_i.select_direction_bit;
    sel_active  = sel_s == cfg_i.select_polarity_bit;
    baud_reload = (cfg_i.baud_div == '0) ? BAUD_MAX : cfg_i.baud_div - BAUD_ONE;
    half_tick   = baud_cnt_r == '0;
    // master edges come from its own divider, slave edges from the synced pin
    if (is_master) begin
      lead  = half_tick & (sck_r == cfg_i.clock_polarity_bit);
      trail = half_tick & (sck_r != cfg_i.clock_polarity_bit);
      smp   = miso_s;
    end else begin
      lead  = (sck_s != sck_prev_r) & (sck_s != cfg_i.clock_polarity_bit);
      trail = (sck_s != sck_prev_r) & (sck_s == cfg_i.clock_polarity_bit);
      smp   = mosi_s;
    end
    case (mode)
      MODE_SPI:   start_ok = ~rx_full_r;
      MODE_PULSE: start_ok = sel_value_r | (head.has_cmd & head.select_value_bit);
      default:    start_ok = 1'b1;
    endcase
  end

  always_comb begin
    state_nxt     = state_r;
    bit_cnt_nxt   = bit_cnt_r;
    lead_cnt_nxt  = lead_cnt_r;
    sck_nxt       = sck_r;
    sck_prev_nxt  = sck_s;
    tx_shift_nxt  = tx_shift_r;
    rx_shift_nxt  = rx_shift_r;
    rx_data_nxt   = rx_data_r;
    rx_full_nxt   = rx_full_r & ~rx_read_i;
    sel_value_nxt = sel_value_r;
    eof_nxt       = eof_r;
    frame_lvl_nxt = frame_lvl_r;
    ones_nxt      = ones_r;
    pop           = 1'b0;
    load_ones     = 1'b0;
    done          = 1'b0;
    set_err       = '0;
    baud_cnt_nxt  = (half_tick || state_r == ST_IDLE) ? baud_reload : baud_cnt_r - BAUD_ONE;
    case (state_r)
      ST_IDLE: begin
        sck_nxt     = cfg_i.clock_polarity_bit;
        bit_cnt_nxt = '0;
        if (is_master && fifo_valid && start_ok) begin
          pop = 1'b1;
          // pulse and framing frames open with one sck period of lead
          state_nxt = (mode == MODE_SPI) ? ST_SHIFT : ST_LEAD;
          frame_lvl_nxt = head.has_cmd ? head.select_value_bit : sel_value_r;
        end else if (is_slave && sel_active) begin
          pop       = fifo_valid;
          load_ones = ~fifo_valid;
          state_nxt = ST_SHIFT;
        end
      end
      ST_LEAD: begin
        if (!is_master) begin
          state_nxt = ST_IDLE;
        end else if (half_tick) begin
          sck_nxt      = ~sck_r;
          lead_cnt_nxt = ~lead_cnt_r;
          if (lead_cnt_r == LEAD_LAST_HALF) begin
            state_nxt = ST_SHIFT;
          end
        end
      end
      ST_SHIFT: begin
        if (!is_master && (!is_slave || !sel_active)) begin
          state_nxt = ST_IDLE;
        end else begin
          if (is_master && half_tick) begin
            sck_nxt = ~sck_r;
          end
          if (lead) begin
            rx_shift_nxt = {rx_shift_r[CHAR_W-2:0], smp};
            if (ones_r && bit_cnt_r == '0) begin
              set_err.tx_underrun_flag = 1'b1;
              ones_nxt                 = 1'b0;
            end
          end
          if (trail) begin
            if (bit_cnt_r == LAST_BIT) begin
              done        = 1'b1;
              bit_cnt_nxt = '0;
            end else begin
              tx_shift_nxt = {tx_shift_r[CHAR_W-2:0], 1'b1};
              bit_cnt_nxt  = bit_cnt_r + 1'b1;
            end
            // next channel level goes out one period ahead of its data
            if (is_master && mode == MODE_FRAMING && bit_cnt_r == PRE_LAST_BIT
                && fifo_valid && head.has_cmd) begin
              frame_lvl_nxt = head.select_value_bit;
            end
          end
        end
        if (done) begin
          // a read in the same cycle frees the buffer, so the new character wins
          if (rx_full_r && !rx_read_i) begin
            set_err.rx_overrun_flag = 1'b1;
          end else begin
            rx_data_nxt = rx_shift_r;
            rx_full_nxt = 1'b1;
          end
          if (!is_master) begin
            pop       = fifo_valid;
            load_ones = ~fifo_valid;
          end else if (mode == MODE_SPI) begin
            // pause here until data is read and rewritten
            state_nxt = ST_IDLE;
            if (eof_r) begin
              sel_value_nxt = 1'b0;
              eof_nxt       = 1'b0;
            end
          end else if (fifo_valid) begin
            pop = 1'b1;
          end else begin
            set_err.tx_underrun_flag = 1'b1;
            sel_value_nxt            = 1'b0;
            frame_lvl_nxt            = 1'b0;
            state_nxt                = ST_IDLE;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (pop) begin
      tx_shift_nxt = head.data;
      ones_nxt     = 1'b0;
      if (head.has_cmd) begin
        sel_value_nxt = head.select_value_bit;
        eof_nxt       = head.end_of_frame_bit;
      end
    end
    if (load_ones) begin
      tx_shift_nxt = ALL_ONES;
      ones_nxt     = 1'b1;
    end
    // a software write lands after any hardware clear
    if (cmd_wr_i) begin
      sel_value_nxt = cmd_select_i;
      eof_nxt       = cmd_eof_i;
    end
    if (is_master && !cfg_i.select_direction_bit && sel_active) begin
      set_err.collision_flag = 1'b1;
    end
    err_nxt = (err_r & ~err_clr_i) | set_err;
    case (mode)
      MODE_SPI:     sel_assert = sel_value_r;
      MODE_PULSE:   sel_assert = state_r == ST_LEAD;
      MODE_FRAMING: sel_assert = frame_lvl_r;
      default:      sel_assert = 1'b0;
    endcase
    sel_pin_nxt = ~(sel_assert ^ cfg_i.select_polarity_bit);
    oe_n_nxt    = {~is_master, ~(is_master & cfg_i.select_direction_bit), ~is_master,
                   ~(is_slave & sel_active)};
    status_nxt  = '{transfer_status_bit: state_nxt != ST_IDLE,
                    tx_buffer_empty_flag: ~fifo_valid, rx_buffer_full_flag: rx_full_nxt, err: err_nxt};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= '0;
      baud_cnt_r  <= '0;
      lead_cnt_r  <= 1'b0;
      sck_r       <= 1'b0;
      sck_prev_r  <= 1'b1;
      tx_shift_r  <= ALL_ONES;
      rx_shift_r  <= '0;
      rx_data_r   <= '0;
      rx_full_r   <= 1'b0;
      sel_value_r <= 1'b0;
      eof_r       <= 1'b0;
      frame_lvl_r <= 1'b0;
      ones_r      <= 1'b0;
      sel_pin_r   <= 1'b1;
      oe_n_r      <= '1;
      err_r       <= '0;
      status_r    <= '{transfer_status_bit: 1'b0, tx_buffer_empty_flag: 1'b1,
                       rx_buffer_full_flag: 1'b0, err: '0};
    end else begin
      state_r     <= state_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      baud_cnt_r  <= baud_cnt_nxt;
      lead_cnt_r  <= lead_cnt_nxt;
      sck_r       <= sck_nxt;
      sck_prev_r  <= sck_prev_nxt;
      tx_shift_r  <= tx_shift_nxt;
      rx_shift_r  <= rx_shift_nxt;
      rx_data_r   <= rx_data_nxt;
      rx_full_r   <= rx_full_nxt;
      sel_value_r <= sel_value_nxt;
      eof_r       <= eof_nxt;
      frame_lvl_r <= frame_lvl_nxt;
      ones_r      <= ones_nxt;
      sel_pin_r   <= sel_pin_nxt;
      oe_n_r      <= oe_n_nxt;
      err_r       <= err_nxt;
      status_r    <= status_nxt;
    end
  end

  assign sck_o          = sck_r;
  assign sel_o          = sel_pin_r;
  assign mosi_o         = tx_shift_r[CHAR_W-1];
  assign miso_o         = tx_shift_r[CHAR_W-1];
  assign {sck_oe_n_o, sel_oe_n_o, mosi_oe_n_o, miso_oe_n_o} = oe_n_r;
  assign rx_valid_o     = rx_full_r;
  assign rx_data_o      = rx_data_r;
  assign status_o       = status_r;
  assign select_value_o = sel_value_r;
  assign end_of_frame_o = eof_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_SPI_SELECT: assert property (is_master && mode == MODE_SPI |=>
    sel_o == ~($past(sel_value_r) ^ $past(cfg_i.select_polarity_bit)))
    else $error("select pin does not follow select value");
  AST_EOF_CLEAR: assert property (done && is_master && mode == MODE_SPI && eof_r && !cmd_wr_i |=>
    !sel_value_r && !eof_r && state_r == ST_IDLE)
    else $error("end of frame did not clear command bits");
  AST_SPI_NO_ERR: assert property (is_master && mode == MODE_SPI |->
    !set_err.tx_underrun_flag && !set_err.rx_overrun_flag)
    else $error("spi master raised a data error");
  AST_SPI_PAUSE: assert property (is_master && mode == MODE_SPI && state_r == ST_IDLE
    && rx_full_r && !rx_read_i |=> state_r == ST_IDLE)
    else $error("spi master did not pause");
  AST_SCK_QUIET: assert property ((is_master && mode == MODE_SPI && state_r == ST_IDLE)[*2] |->
    $stable(sck_o))
    else $error("sck toggled outside a character");
  AST_SLAVE_ONES: assert property (load_ones |=> tx_shift_r == ALL_ONES && miso_o)
    else $error("slave did not load all ones");
  AST_PULSE_SEL: assert property (is_master && mode == MODE_PULSE && state_r == ST_LEAD |=>
    sel_o == $past(cfg_i.select_polarity_bit))
    else $error("frame pulse not asserted during lead");
  AST_FRAME_UNDERRUN: assert property (done && is_master && mode != MODE_SPI && !fifo_valid
    && !cmd_wr_i |=> err_r.tx_underrun_flag && !sel_value_r && state_r == ST_IDLE)
    else $error("empty buffer did not end the frame");
  AST_COLLISION: assert property (is_master && !cfg_i.select_direction_bit && sel_active |=>
    err_r.collision_flag)
    else $error("collision not flagged");
  AST_SWAP: assert property (done && !rx_full_r |=> rx_full_r && rx_data_r == $past(rx_shift_r))
    else $error("received character not made readable");
  AST_W1C: assert property (err_r.rx_overrun_flag && !err_clr_i.rx_overrun_flag |=>
    err_r.rx_overrun_flag)
    else $error("overrun flag cleared without a write of one");
  AST_SLAVE_IGNORE: assert property (!is_master && state_r == ST_SHIFT && !sel_active |=>
    state_r == ST_IDLE ##1 state_r == ST_IDLE || sel_active)
    else $error("slave kept shifting without select");

  COV_SPI_CHAR: cover property (done && is_master && mode == MODE_SPI);
  COV_PULSE_LEAD: cover property (state_r == ST_LEAD ##[1:300] state_r == ST_SHIFT);
  COV_SLAVE_UNDERRUN: cover property (!is_master && set_err.tx_underrun_flag);

endmodule : ssp_frame_select

// >>> spi_master_model.sv
// behavioural external serial master, phase 0, idle-low clock
`timescale 1ns/1ps
module spi_master_model (
  // pins
  output logic      sck_o,
  output logic      sel_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // clock stands still between frames
  initial begin
    sck_o   = 1'b0;
    sel_n_o = 1'b1;
    mosi_o  = 1'b0;
  end
  // 125 ns period keeps well under a quarter of the system clock
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    int i;
    sel_n_o = 1'b0;
    for (i = 7; i >= 0; i--) begin
      mosi_o = d[i];
      #62.5 sck_o = 1'b1;
      r[i] = miso_i;
      #62.5 sck_o = 1'b0;
    end
    // released line shows the inverse, not a stale bit
    #62.5 mosi_o = ~mosi_o;
    sel_n_o = 1'b1;
    #250;
  endtask : xfer
endmodule : spi_master_model

// >>> tb_ssp_frame_select.sv
// self-checking bench of the frame-select engine
`timescale 1ns/1ps
module tb_ssp_frame_select;
  import ssp_pkg::*;
  logic              clk, rst, cmd_wr, cmd_sel, cmd_eof, tx_valid, rx_read, tx_ready, rx_valid;
  logic              sel_val, sck_o, sel_o, mosi_o, miso_o, m_sck, m_sel_n, m_mosi, eof, sel_oe_n;
  cfg_type           cfg;
  tx_word_type       tx_word;
  err_type           err_clr;
  status_type        status;
  logic [CHAR_W-1:0] rx_data, d, r, got;
  int                seed = 68150, failures = 0, compares = 0, cycles = 0, i;

  ssp_frame_select #(.DEPTH(FIFO_DEPTH)) uut (.clk_i(clk), .rst_i(rst), .cfg_i(cfg), .cmd_wr_i(cmd_wr),
    .cmd_select_i(cmd_sel), .cmd_eof_i(cmd_eof), .tx_valid_i(tx_valid), .tx_word_i(tx_word),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_read_i(rx_read),
    .status_o(status), .err_clr_i(err_clr), .select_value_o(sel_val), .end_of_frame_o(eof),
    .sck_i(m_sck), .sck_o(sck_o), .sck_oe_n_o(), .sel_i(m_sel_n), .sel_o(sel_o), .sel_oe_n_o(sel_oe_n),
    .mosi_i(m_mosi), .mosi_o(mosi_o), .mosi_oe_n_o(), .miso_i(mosi_o), .miso_o(miso_o), .miso_oe_n_o());
  spi_master_model model (.sck_o(m_sck), .sel_n_o(m_sel_n), .mosi_o(m_mosi), .miso_i(miso_o));

  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk8(input logic [CHAR_W-1:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, e, input string m);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t %s got %b", $time, m, g);
    end
  endtask : chk1
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic push(input tx_word_type w);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_word  <= w;
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask : push
  task automatic wait_rx;
    for (i = 0; i < 5000 && rx_valid !== 1'b1; i++) tick(1);
  endtask : wait_rx
  task automatic get(input logic [CHAR_W-1:0] e);
    wait_rx();
    chk8(rx_data, e, "rx data");
    @(posedge clk);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    // let the cleared full flag settle before the next look
    tick(1);
  endtask : get
  task automatic setcfg(input logic m, sd, input logic [1:0] md);
    @(posedge clk);
    cfg <= '{1'b1, m, sd, 1'b0, 1'b0, md, 16'h0004};
  endtask : setcfg
  task automatic clr_err(input err_type e);
    @(posedge clk);
    err_clr <= e;
    @(posedge clk);
    err_clr <= '0;
    tick(2);
  endtask : clr_err

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    {rst, cmd_wr, cmd_sel, cmd_eof, tx_valid, rx_read} = 6'h20;
    cfg = '0;
    tx_word = '0;
    err_clr = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk1(status.tx_buffer_empty_flag, 1'b1, "reset empty");
    chk1(tx_ready, 1'b1, "reset ready");
    setcfg(1'b1, 1'b1, MODE_SPI);
    @(posedge clk);
    {cmd_wr, cmd_sel} <= 2'h3;
    @(posedge clk);
    cmd_wr <= 1'b0;
    tick(3);
    chk1(sel_o, 1'b0, "spi select");
    chk1(sel_oe_n, 1'b0, "select driven");
    d = CHAR_W'($random(seed));
    r = CHAR_W'($random(seed));
    push('{1'b0, 1'b0, 1'b0, d});
    push('{1'b1, 1'b1, 1'b1, r});
    wait_rx();
    // rx left full: master must pause, not overrun
    tick(40);
    chk1(sck_o, 1'b0, "sck paused");
    chk1(sel_o, 1'b0, "select held");
    get(d);
    get(r);
    tick(4);
    chk1(sel_val, 1'b0, "eof clears value");
    chk1(sel_o, 1'b1, "select released");
    chk1(eof, 1'b0, "eof cleared");
    chk1(status.transfer_status_bit, 1'b0, "idle");
    chk1(status.err.tx_underrun_flag, 1'b0, "no underrun");
    for (int k = 2; k < 4; k++) begin
      setcfg(1'b1, 1'b1, 2'(k));
      d = CHAR_W'($random(seed));
      push('{1'b1, 1'b1, 1'b0, d});
      get(d);
      tick(20);
      chk1(status.err.tx_underrun_flag, 1'b1, "underrun");
      chk1(sel_val, 1'b0, "value cleared");
      clr_err('{1'b1, 1'b0, 1'b0});
      chk1(status.err.tx_underrun_flag, 1'b0, "write one clears");
    end
    setcfg(1'b0, 1'b0, MODE_SPI);
    d = CHAR_W'($random(seed));
    r = CHAR_W'($random(seed));
    push('{1'b0, 1'b0, 1'b0, d});
    tick(4);
    model.xfer(r, got);
    chk8(got, d, "slave out");
    get(r);
    // nothing written: slave has to send ones
    model.xfer(d, got);
    chk8(got, 8'hff, "ones");
    chk1(status.err.tx_underrun_flag, 1'b1, "slave underrun");
    // rx still full: the next character overruns and the old data is kept
    model.xfer(r, got);
    chk1(status.err.rx_overrun_flag, 1'b1, "slave overrun");
    get(d);
    setcfg(1'b1, 1'b0, MODE_SPI);
    tick(4);
    model.xfer(d, got);
    chk1(status.err.collision_flag, 1'b1, "collision");
    chk1(sel_oe_n, 1'b1, "select is input");
    end_of_test();
  end
endmodule : tb_ssp_frame_select
